// *** fds_consts.svh ***
// Constants for the drive fault supervisor: offsets, fields, resets, timing
`ifndef FDS_CONSTS_SVH
`define FDS_CONSTS_SVH

// Timing
`define FDS_CLK_PERIOD_NS      5
`define FDS_NS_PER_MS          1000000
`define FDS_CYC_PER_MS         ((`FDS_NS_PER_MS) / (`FDS_CLK_PERIOD_NS))
`define FDS_SERIAL_TIMEOUT_MS  2000
`define FDS_OPER_STARTUP_MS    5000
`define FDS_LOW_CUR_PCT        25
`define FDS_PCT_FULL           100

// Register offsets (byte addresses)
`define FDS_OFF_CTRL           8'h00
`define FDS_OFF_CTIME          8'h04
`define FDS_OFF_NOLOAD         8'h08
`define FDS_OFF_STATUS         8'h0c
`define FDS_OFF_MASK           8'h10
`define FDS_OFF_CODE           8'h14
`define FDS_OFF_LIVE           8'h18

// Control fields and the code register active bit
`define FDS_CTRL_RUNSRC_LSB    0
`define FDS_CTRL_RUNSRC_MSB    1
`define FDS_CTRL_STOP_LSB      2
`define FDS_CTRL_STOP_MSB      4
`define FDS_CTRL_TOEN          5
`define FDS_CTRL_FRST          8
`define FDS_CODE_ACTIVE        8

// Reset values and setting codes
`define FDS_RUNSRC_RST         2'h0
`define FDS_STOP_RST           3'h0
`define FDS_TOEN_RST           1'h0
`define FDS_CTIME_RST          16'h03e8
`define FDS_NOLOAD_RST         16'h0000
`define FDS_RUNSRC_OPER        2'h0
`define FDS_STOP_MAX           3'h2
`define FDS_TOEN_ON            1'h1

// Fault bit positions; fault code is bit position plus one
`define FDS_F_OPT              0
`define FDS_F_TERM_LSB         1
`define FDS_F_TERM_MSB         5
`define FDS_F_OPER_DISC        6
`define FDS_F_SER              7
`define FDS_F_BUS              8
`define FDS_F_CTR              9
`define FDS_F_BRK              10
`define FDS_F_RUN              11
`define FDS_F_OPS              12
`define FDS_F_RAM              13
`define FDS_NFAULT             14

// AXI responses
`define FDS_RESP_OKAY          2'h0
`define FDS_RESP_SLVERR        2'h2

`endif

// *** fds_pkg.sv ***
// Types shared by the drive fault supervisor
`include "fds_consts.svh"
package fds_pkg;
   typedef logic [`FDS_NFAULT-1:0] fds_fault_t;
   typedef logic [7:0]             fds_code_t;
   typedef enum logic [1:0] {
      OPS_WAIT,
      OPS_LINKED,
      OPS_TIMED_OUT
   } fds_opst_e;
endpackage

// *** fds_tmr_if.sv ***
// Carrier between the supervisor and its millisecond timers
`timescale 1ns/10ps
interface fds_tmr_if #(parameter int W = 16);
   logic         run;
   logic [W-1:0] limit;
   logic         tick;
   logic         expired;
   modport ctl (output run, output limit, output tick, input expired);
   modport tmr (input run, input limit, input tick, output expired);
endinterface // fds_tmr_if

// *** fds_tmr.sv ***
// Millisecond timeout counter, cleared whenever run drops
`timescale 1ns/10ps
module fds_tmr #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   fds_tmr_if.tmr   t
);
   logic [W-1:0] cnt_q;
   logic         exp_q;

   if (W < 1) begin : g_bad_w
      $error("fds_tmr: W must be at least 1");
   end

   // Saturates at the limit so a held condition keeps the flag up
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
      end else if (!t.run) begin
         cnt_q <= '0;
      end else if (t.tick && (cnt_q < t.limit)) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         exp_q <= 1'b0;
      end else begin
         exp_q <= t.run && (cnt_q >= t.limit);
      end
   end

   assign t.expired = exp_q;

   AST_TMR_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
      !t.run |=> !t.expired)
      else $error("timer flag stayed up after run dropped");
endmodule // fds_tmr

// *** fds_supervisor.sv ***
// Drive fault supervisor: fault detection, latching and AXI4-Lite registers
//
// Contract
// - Option board external fault input raises its own fault code.
// - Each of five multi-function terminals raises its own external fault.
// - Operator removed while run source selects operator raises disconnect fault.
// - No good serial control data for two seconds raises serial fault.
// - Serial check active only with stop method 0 to 2 and timeout on.
// - No contactor answer within the set answer time raises sequence fault one.
// - Current below 25% of no-load at brake opening raises fault two.
// - Current below 25% of no-load while running raises fault three.
// - Operator link not up within 5 s of power-up raises fault.
// - External RAM fault raises its own fault code.
`timescale 1ns/10ps
`include "fds_consts.svh"
module fds_supervisor #(
   parameter int ADDR_W        = 8,
   parameter int CYC_PER_MS    = `FDS_CYC_PER_MS,
   parameter int SER_TIMEOUT_MS = `FDS_SERIAL_TIMEOUT_MS,
   parameter int OPS_TIMEOUT_MS = `FDS_OPER_STARTUP_MS
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // External fault sources
   input  wire logic              option_external_fault,
   input  wire logic              multi_input_3,
   input  wire logic              multi_input_4,
   input  wire logic              multi_input_5,
   input  wire logic              multi_input_6,
   input  wire logic              multi_input_7,
   input  wire logic              ext_ram_fault,
   // Links
   input  wire logic              operator_present,
   input  wire logic              operator_link_ok,
   input  wire logic              serial_rx_good,
   input  wire logic              option_link_up,
   // Contactor and motor
   input  wire logic              contactor_close_cmd,
   input  wire logic              contactor_answer,
   input  wire logic              brake_open,
   input  wire logic              motor_running,
   input  wire logic [15:0]       output_current,
   // Fault outputs
   output fds_pkg::fds_code_t     fault_code,
   output logic                   fault_active,
   output logic                   irq
);
   import fds_pkg::*;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   if (ADDR_W < 8 || CYC_PER_MS < 1 || SER_TIMEOUT_MS >= 65536 ||
       OPS_TIMEOUT_MS >= 65536) begin : g_bad_par
      $error("fds_supervisor: parameter out of range");
   end

   // Settings and interrupt state
   logic [1:0]  runsrc_q;
   logic [2:0]  stop_q;
   logic        toen_q;
   logic [15:0] ctime_q;
   logic [15:0] noload_q;
   fds_fault_t  status_q;
   fds_fault_t  mask_q;
   fds_code_t   code_q;
   logic        active_q;
   logic        irq_q;
   logic        opt_est_q;
   fds_opst_e   ops_q;

   // Bus state
   logic              awrdy_q, wrdy_q, aw_full_q, w_full_q;
   logic              bvalid_q, arrdy_q, rvalid_q;
   logic [1:0]        bresp_q, rresp_q;
   logic [31:0]       rdata_q, wdata_q;
   logic [3:0]        wstrb_q;
   logic [ADDR_W-1:0] awaddr_q;

   logic [31:0] ms_cnt_q;
   logic        tick_q;

   fds_fault_t  cond;
   logic [4:0]  term;
   logic        cur_low, ser_en;
   logic        wr_fire, wr_hit, rd_hit, frst;
   logic [31:0] wr_old, rd_word, wr_mrg, bmask;
   fds_fault_t  w1c;

   fds_tmr_if #(.W(16)) tif[3] ();

   for (genvar g = 0; g < 3; g++) begin : g_tmr
      fds_tmr #(.W(16)) u_tmr (
         .aclk    (aclk),
         .aresetn (aresetn),
         .t       (tif[g].tmr)
      );
      assign tif[g].tick = tick_q;
   end

   // Millisecond prescaler keeps the timers narrow
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ms_cnt_q <= 32'h0;
         tick_q   <= 1'b0;
      end else if (ms_cnt_q == 32'(CYC_PER_MS - 1)) begin
         ms_cnt_q <= 32'h0;
         tick_q   <= 1'b1;
      end else begin
         ms_cnt_q <= ms_cnt_q + 32'h1;
         tick_q   <= 1'b0;
      end
   end

   // Timer 0: serial link, restarted by every good frame
   assign ser_en = (stop_q <= `FDS_STOP_MAX) && (toen_q == `FDS_TOEN_ON);
   assign tif[0].run   = ser_en && !serial_rx_good;
   assign tif[0].limit = 16'(SER_TIMEOUT_MS);
   // Timer 1: contactor answer-back
   assign tif[1].run   = contactor_close_cmd && !contactor_answer;
   assign tif[1].limit = ctime_q;
   // Timer 2: operator link after power-up
   assign tif[2].run   = (ops_q == OPS_WAIT);
   assign tif[2].limit = 16'(OPS_TIMEOUT_MS);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ops_q <= OPS_WAIT;
      end else begin
         case (ops_q)
            OPS_WAIT: begin
               if (operator_link_ok) begin
                  ops_q <= OPS_LINKED;
               end else if (tif[2].expired) begin
                  ops_q <= OPS_TIMED_OUT;
               end
            end
            OPS_LINKED:    ops_q <= OPS_LINKED;
            OPS_TIMED_OUT: ops_q <= OPS_TIMED_OUT;
            default:       ops_q <= OPS_WAIT;
         endcase
      end
   end

   // A drop before the first connection is not a fault
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         opt_est_q <= 1'b0;
      end else if (option_link_up) begin
         opt_est_q <= 1'b1;
      end
   end

   assign term = {multi_input_7, multi_input_6, multi_input_5,
                  multi_input_4, multi_input_3};
   assign cur_low = (32'(output_current) * `FDS_PCT_FULL) <
                    (32'(noload_q) * `FDS_LOW_CUR_PCT);

   always_comb begin
      cond = '0;
      cond[`FDS_F_OPT] = option_external_fault;
      cond[`FDS_F_TERM_MSB:`FDS_F_TERM_LSB] = term;
      cond[`FDS_F_OPER_DISC] = !operator_present && (runsrc_q == `FDS_RUNSRC_OPER);
      // Gated so a flag still up from before the check was switched off is ignored
      cond[`FDS_F_SER] = tif[0].expired && ser_en;
      cond[`FDS_F_BUS] = opt_est_q && !option_link_up;
      cond[`FDS_F_CTR] = tif[1].expired;
      cond[`FDS_F_BRK] = brake_open && cur_low;
      cond[`FDS_F_RUN] = motor_running && cur_low;
      cond[`FDS_F_OPS] = (ops_q == OPS_TIMED_OUT);
      cond[`FDS_F_RAM] = ext_ram_fault;
   end

   // Sticky status: a condition present in the clearing cycle wins
   for (genvar i = 0; i < `FDS_NFAULT; i++) begin : g_stat
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            status_q[i] <= 1'b0;
         end else begin
            status_q[i] <= cond[i] | (status_q[i] & ~w1c[i]);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & mask_q);
      end
   end

   function automatic fds_code_t first_code(input fds_fault_t f);
      fds_code_t c;
      c = 8'h00;
      for (int k = `FDS_NFAULT - 1; k >= 0; k--) begin
         if (f[k]) begin
            c = 8'(k + 1);
         end
      end
      return c;
   endfunction

   // Only the first fault is kept so the display shows the root cause
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         code_q   <= 8'h00;
         active_q <= 1'b0;
      end else if (frst) begin
         code_q   <= first_code(cond);
         active_q <= |cond;
      end else if (!active_q && |cond) begin
         code_q   <= first_code(cond);
         active_q <= 1'b1;
      end
   end

   // Write channel: address and data taken in either order
   assign wr_fire = aw_full_q && w_full_q && !bvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awrdy_q   <= 1'b0;
         aw_full_q <= 1'b0;
         awaddr_q  <= '0;
      end else if (s_axi_awvalid && awrdy_q) begin
         awrdy_q   <= 1'b0;
         aw_full_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_full_q <= 1'b0;
      end else begin
         awrdy_q   <= !aw_full_q && !bvalid_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wrdy_q   <= 1'b0;
         w_full_q <= 1'b0;
         wdata_q  <= 32'h0;
         wstrb_q  <= 4'h0;
      end else if (s_axi_wvalid && wrdy_q) begin
         wrdy_q   <= 1'b0;
         w_full_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_full_q <= 1'b0;
      end else begin
         wrdy_q   <= !w_full_q && !bvalid_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `FDS_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit ? `FDS_RESP_OKAY : `FDS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign wr_mrg = (wr_old & ~bmask) | (wdata_q & bmask);
   assign frst = wr_fire && (awaddr_q[7:0] == `FDS_OFF_CTRL) && wr_mrg[`FDS_CTRL_FRST];
   assign w1c = (wr_fire && awaddr_q[7:0] == `FDS_OFF_STATUS) ?
                `FDS_NFAULT'(wdata_q & bmask) : '0;

   always_comb begin
      wr_hit = 1'b1;
      wr_old = 32'h0;
      case (awaddr_q[7:0])
         `FDS_OFF_CTRL:   wr_old = {26'h0, toen_q, stop_q, runsrc_q};
         `FDS_OFF_CTIME:  wr_old = {16'h0, ctime_q};
         `FDS_OFF_NOLOAD: wr_old = {16'h0, noload_q};
         `FDS_OFF_MASK:   wr_old = {18'h0, mask_q};
         `FDS_OFF_STATUS: wr_old = 32'h0;
         default:         wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         runsrc_q <= `FDS_RUNSRC_RST;
         stop_q   <= `FDS_STOP_RST;
         toen_q   <= `FDS_TOEN_RST;
      end else if (wr_fire && awaddr_q[7:0] == `FDS_OFF_CTRL) begin
         runsrc_q <= wr_mrg[`FDS_CTRL_RUNSRC_MSB:`FDS_CTRL_RUNSRC_LSB];
         stop_q   <= wr_mrg[`FDS_CTRL_STOP_MSB:`FDS_CTRL_STOP_LSB];
         toen_q   <= wr_mrg[`FDS_CTRL_TOEN];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctime_q  <= `FDS_CTIME_RST;
         noload_q <= `FDS_NOLOAD_RST;
         mask_q   <= '0;
      end else if (wr_fire) begin
         if (awaddr_q[7:0] == `FDS_OFF_CTIME) begin
            ctime_q <= wr_mrg[15:0];
         end
         if (awaddr_q[7:0] == `FDS_OFF_NOLOAD) begin
            noload_q <= wr_mrg[15:0];
         end
         if (awaddr_q[7:0] == `FDS_OFF_MASK) begin
            mask_q <= wr_mrg[`FDS_NFAULT-1:0];
         end
      end
   end

   // Read channel: one read in flight; data answered the cycle after address
   always_comb begin
      rd_hit  = 1'b1;
      rd_word = 32'h0;
      case (s_axi_araddr[7:0])
         `FDS_OFF_CTRL:   rd_word = {26'h0, toen_q, stop_q, runsrc_q};
         `FDS_OFF_CTIME:  rd_word = {16'h0, ctime_q};
         `FDS_OFF_NOLOAD: rd_word = {16'h0, noload_q};
         `FDS_OFF_STATUS: rd_word = {18'h0, status_q};
         `FDS_OFF_MASK:   rd_word = {18'h0, mask_q};
         `FDS_OFF_CODE:   rd_word = {23'h0, active_q, code_q};
         `FDS_OFF_LIVE:   rd_word = {18'h0, cond};
         default:         rd_hit  = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arrdy_q  <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0;
         rresp_q  <= `FDS_RESP_OKAY;
      end else if (s_axi_arvalid && arrdy_q) begin
         arrdy_q  <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word;
         rresp_q  <= rd_hit ? `FDS_RESP_OKAY : `FDS_RESP_SLVERR;
      end else if (rvalid_q) begin
         rvalid_q <= !s_axi_rready;
      end else begin
         arrdy_q  <= 1'b1;
      end
   end

   assign s_axi_awready = awrdy_q;
   assign s_axi_wready  = wrdy_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arrdy_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign fault_code    = code_q;
   assign fault_active  = active_q;
   assign irq           = irq_q;

   sequence s_link_lost;
      option_link_up ##1 !option_link_up;
   endsequence

   sequence s_oper_late;
      !operator_link_ok && ops_q == OPS_WAIT ##0 tif[2].expired;
   endsequence

   AST_OPT_EXT: assert property (option_external_fault |=> status_q[`FDS_F_OPT])
      else $error("option external fault not flagged");
   AST_TERM: assert property (1'b1 |=>
      ((status_q[`FDS_F_TERM_MSB:`FDS_F_TERM_LSB] & $past(term)) == $past(term)))
      else $error("terminal external fault not flagged");
   AST_OPER_DISC: assert property ((!operator_present && runsrc_q == `FDS_RUNSRC_OPER)
      |=> status_q[`FDS_F_OPER_DISC])
      else $error("operator disconnect not flagged");
   AST_SER_SET: assert property ($rose(status_q[`FDS_F_SER]) |-> $past(tif[0].expired))
      else $error("serial fault raised without timeout");
   AST_SER_EN: assert property (!ser_en |=> !status_q[`FDS_F_SER] ||
      $past(status_q[`FDS_F_SER]))
      else $error("serial fault raised while detection off");
   AST_BUS: assert property (s_link_lost |=> status_q[`FDS_F_BUS])
      else $error("option link loss not flagged");
   AST_BUS_EARLY: assert property (!opt_est_q |-> !cond[`FDS_F_BUS])
      else $error("option link fault before first connection");
   AST_CTR: assert property (contactor_answer |=> !tif[1].expired)
      else $error("contactor timer ran despite answer");
   AST_BRK: assert property ((brake_open && cur_low) |=> status_q[`FDS_F_BRK])
      else $error("low current at brake opening not flagged");
   AST_RUN: assert property ((motor_running && cur_low) |=> status_q[`FDS_F_RUN])
      else $error("low running current not flagged");
   AST_OPS: assert property (s_oper_late |=> ##1 status_q[`FDS_F_OPS])
      else $error("operator startup timeout not flagged");
   AST_RAM: assert property (ext_ram_fault |=> status_q[`FDS_F_RAM])
      else $error("external RAM fault not flagged");
   AST_HOLD: assert property ((active_q && !frst) |=> active_q && $stable(code_q))
      else $error("latched fault code changed without reset");
   AST_IRQ: assert property (1'b1 |=> irq_q == $past(|(status_q & mask_q)))
      else $error("interrupt does not follow masked status");

endmodule // fds_supervisor

// *** fds_partner.sv ***
// Far-side model: operator panel link, serial control master, contactor answer-back
`timescale 1ns/10ps
module fds_partner (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Scenario controls
   input  wire logic       link_en,
   input  wire logic       ser_en,
   input  wire logic [7:0] ans_dly,
   // Far-side signals
   input  wire logic       contactor_close_cmd,
   output logic            operator_link_ok,
   output logic            serial_rx_good,
   output logic            contactor_answer
);
   logic [3:0] frame_q;
   logic [7:0] wait_q;
   // A frame every 16 cycles stays well inside the shortened serial timeout
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_q <= 4'h0;
         serial_rx_good <= 1'b0;
      end else begin
         frame_q <= frame_q + 4'h1;
         serial_rx_good <= ser_en && (frame_q == 4'hf);
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) operator_link_ok <= 1'b0;
      else operator_link_ok <= link_en;
   end
   // A delay of 8'hff stands for a contactor that never answers
   always_ff @(posedge aclk) begin
      if (!aresetn || !contactor_close_cmd) begin
         wait_q <= 8'h00;
         contactor_answer <= 1'b0;
      end else begin
         if (wait_q != 8'hff) wait_q <= wait_q + 8'h01;
         contactor_answer <= (ans_dly != 8'hff) && (wait_q >= ans_dly);
      end
   end
endmodule // fds_partner

// *** fds_supervisor_bench.sv ***
// Self-checking testbench for the drive fault supervisor
`timescale 1ns/10ps
`include "fds_consts.svh"
module fds_supervisor_bench;
   import fds_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, link_ok, ser_good, answer;
   logic [1:0]  bresp, rresp, r;
   logic [31:0] rdata, v;
   logic [6:0]  src = 7'h00;
   logic        op_present = 1'b1, opt_up = 1'b0, close_cmd = 1'b0, brake = 1'b0;
   logic        running = 1'b0, link_en = 1'b1, ser_en = 1'b1, f_active, irq;
   logic [15:0] current = 16'h0000;
   logic [7:0]  ans_dly = 8'h02;
   fds_code_t   f_code;
   int          n_mismatch = 0, num_checks = 0, cyc = 0;

   fds_supervisor #(.CYC_PER_MS(10), .SER_TIMEOUT_MS(3), .OPS_TIMEOUT_MS(4)) u_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .option_external_fault(src[0]), .multi_input_3(src[1]), .multi_input_4(src[2]),
      .multi_input_5(src[3]), .multi_input_6(src[4]), .multi_input_7(src[5]),
      .ext_ram_fault(src[6]), .operator_present(op_present), .operator_link_ok(link_ok),
      .serial_rx_good(ser_good), .option_link_up(opt_up), .contactor_close_cmd(close_cmd),
      .contactor_answer(answer), .brake_open(brake), .motor_running(running),
      .output_current(current), .fault_code(f_code), .fault_active(f_active), .irq(irq));
   fds_partner u_far (.aclk(aclk), .aresetn(aresetn), .link_en(link_en), .ser_en(ser_en),
      .ans_dly(ans_dly), .contactor_close_cmd(close_cmd), .operator_link_ok(link_ok),
      .serial_rx_good(ser_good), .contactor_answer(answer));

   always #2.5 aclk = ~aclk;
   // The whole sequence needs under a thousand cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      v = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic sbit(input int b, input logic e);
      rd(`FDS_OFF_STATUS);
      chk({31'h0, v[b]}, {31'h0, e});
   endtask
   task automatic clr();
      wr(`FDS_OFF_STATUS, 32'h3fff);
   endtask

   initial begin
      static int          pos[7] = '{0, 1, 2, 3, 4, 5, 13};
      static logic [31:0] sctl[5] = '{32'h20, 32'h28, 32'h2c, 32'h08, 32'h20};
      static logic        sen[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      static logic        sexp[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      idle(6);
      aresetn <= 1'b1;
      idle(2);
      rd(`FDS_OFF_CTRL);
      chk(v, 32'h0);
      rd(`FDS_OFF_CTIME);
      chk(v, 32'h3e8);
      rd(`FDS_OFF_NOLOAD);
      chk(v, 32'h0);
      rd(`FDS_OFF_MASK);
      chk(v, 32'h0);
      rd(`FDS_OFF_STATUS);
      chk(v, 32'h0);
      rd(`FDS_OFF_CODE);
      chk(v, 32'h0);
      rd(8'h1c);
      chk({30'h0, r}, 32'h2);
      wr(8'h40, 32'h1);
      chk({30'h0, r}, 32'h2);
      // Each source alone; the code must outlive the cleared status bit
      for (int i = 0; i < 7; i++) begin
         wr(`FDS_OFF_CTRL, 32'h100);
         chk({31'h0, f_active}, 32'h0);
         src[i] <= 1'b1;
         idle(3);
         sbit(pos[i], 1'b1);
         src[i] <= 1'b0;
         clr();
         sbit(pos[i], 1'b0);
         rd(`FDS_OFF_CODE);
         chk(v, 32'h100 | 32'(pos[i] + 1));
         chk({24'h0, f_code}, 32'(pos[i] + 1));
      end
      wr(`FDS_OFF_MASK, 32'h1);
      src[0] <= 1'b1;
      idle(3);
      src[0] <= 1'b0;
      chk({24'h0, f_code}, 32'he);
      chk({31'h0, irq}, 32'h1);
      wr(`FDS_OFF_MASK, 32'h0);
      idle(2);
      chk({31'h0, irq}, 32'h0);
      wr(`FDS_OFF_MASK, 32'h1);
      clr();
      idle(2);
      chk({31'h0, irq}, 32'h0);
      op_present <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         wr(`FDS_OFF_CTRL, 32'(k));
         clr();
         idle(3);
         sbit(6, k == 0);
      end
      op_present <= 1'b1;
      for (int k = 0; k < 5; k++) begin
         ser_en <= sen[k];
         wr(`FDS_OFF_CTRL, sctl[k]);
         clr();
         idle(40);
         sbit(7, sexp[k]);
      end
      wr(`FDS_OFF_CTRL, 32'h0);
      opt_up <= 1'b1;
      idle(4);
      sbit(8, 1'b0);
      opt_up <= 1'b0;
      idle(4);
      sbit(8, 1'b1);
      rd(`FDS_OFF_LIVE);
      chk(v, 32'h100);
      opt_up <= 1'b1;
      wr(`FDS_OFF_CTIME, 32'h2);
      for (int k = 0; k < 2; k++) begin
         ans_dly <= (k == 1) ? 8'hff : 8'h02;
         clr();
         close_cmd <= 1'b1;
         idle(30);
         sbit(9, k == 1);
         close_cmd <= 1'b0;
         idle(2);
      end
      // Limit is 25 when no-load is 100: 24 is low, 25 is not
      wr(`FDS_OFF_NOLOAD, 32'h64);
      for (int k = 0; k < 2; k++) begin
         current <= (k == 1) ? 16'h0019 : 16'h0018;
         clr();
         brake <= 1'b1;
         idle(1);
         brake <= 1'b0;
         idle(3);
         sbit(10, k == 0);
         running <= 1'b1;
         idle(3);
         sbit(11, k == 0);
         running <= 1'b0;
      end
      link_en <= 1'b0;
      aresetn <= 1'b0;
      idle(2);
      aresetn <= 1'b1;
      idle(60);
      sbit(12, 1'b1);
      stop_test();
   end
endmodule // fds_supervisor_bench
